// [line_event_pkg.sv]
package line_event_pkg;

    localparam int REG_ADDR_W = 5;
    localparam int REG_DATA_W = 8;

    // register offsets
    localparam logic [4:0] OFS_GLOBAL_CONFIGURATION = 5'h02;
    localparam logic [4:0] OFS_TRANSMIT_CONFIG_1 = 5'h06;
    localparam logic [4:0] OFS_INTERRUPT_MASK_LOW = 5'h14;
    localparam logic [4:0] OFS_INTERRUPT_MASK_HIGH = 5'h15;
    localparam logic [4:0] OFS_INTERRUPT_EDGE_SELECT = 5'h16;
    localparam logic [4:0] OFS_LINE_STATUS_LOW = 5'h17;
    localparam logic [4:0] OFS_LINE_STATUS_HIGH = 5'h18;
    localparam logic [4:0] OFS_INTERRUPT_PENDING_LOW = 5'h19;
    localparam logic [4:0] OFS_INTERRUPT_PENDING_HIGH = 5'h1a;

    // global_configuration fields
    localparam int GCF_INT_MODE_LSB = 0;
    localparam int GCF_LINE_STD_BIT = 2;
    localparam logic [7:0] GCF_WRITE_MASK = 8'h07;

    // transmit_config_1 fields
    localparam int TRANSMIT_CONFIG_1_DRIVER_MONITOR_DISABLE_BIT = 5;
    localparam int TRANSMIT_CONFIG_1_LINE_HIGH_Z_BIT = 4;
    localparam logic [7:0] TRANSMIT_CONFIG_1_WRITE_MASK = 8'h3f;

    // low group bit positions, shared by status, pending, edge select and mask
    localparam int SRC_SIGNAL_LOSS = 0;
    localparam int SRC_ALARM_INDICATION = 1;
    localparam int SRC_DRIVER_FAULT = 2;
    localparam int SRC_TX_CLOCK_LOSS = 3;
    localparam int SRC_PATTERN_SYNC = 4;
    localparam int SRC_LOOP_DEACTIVATE = 5;
    localparam int SRC_LOOP_ACTIVATE = 6;
    localparam int LOW_SOURCES = 7;

    // line_status_high field
    localparam int LINE_STATUS_HIGH_REMOTE_LOOP_BIT = 5;

    // interrupt pin modes
    localparam logic [1:0] INT_MODE_OPEN_DRAIN = 2'h0;
    localparam logic [1:0] INT_MODE_PUSH_PULL_LOW = 2'h1;
    localparam logic [1:0] INT_MODE_PUSH_PULL_HIGH = 2'h2;

    // reset values
    localparam logic [7:0] RST_GLOBAL_CONFIGURATION = 8'h00;
    localparam logic [7:0] RST_TRANSMIT_CONFIG_1 = 8'h00;
    localparam logic [7:0] RST_INTERRUPT_MASK = 8'hff;
    localparam logic [7:0] RST_INTERRUPT_EDGE_SELECT = 8'h00;

    // transmit clock loss: cycles of master clock without a tx clock edge
    localparam int TX_CLOCK_LOSS_CYCLES = 70;

endpackage

// [status_edge_capture.sv]
`timescale 1ns/1ps
`default_nettype none
module status_edge_capture
    import line_event_pkg::*;
#(
    parameter int WIDTH = 7
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] state_in,
    input wire logic [WIDTH-1:0] edge_sel,
    output logic [WIDTH-1:0] event_out
);
    logic [WIDTH-1:0] prev_r;
    logic [WIDTH-1:0] prev_nxt;

    always_comb begin
        prev_nxt = state_in;
        // rising edge always counts, falling edge only when selected
        event_out = (state_in & ~prev_r) | (edge_sel & (state_in ^ prev_r));
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            prev_r <= '0;
        end else begin
            prev_r <= prev_nxt;
        end
    end
endmodule
`default_nettype wire

// [tx_clock_watch.sv]
`timescale 1ns/1ps
`default_nettype none
module tx_clock_watch
    import line_event_pkg::*;
#(
    parameter int LOSS_CYCLES = TX_CLOCK_LOSS_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic tx_clock,
    output logic tx_clock_loss_state
);
    localparam int CNT_W = $clog2(LOSS_CYCLES + 2);
    localparam logic [CNT_W-1:0] LIMIT = CNT_W'(LOSS_CYCLES);

    logic sync1_r;
    logic sync2_r;
    logic sync3_r;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic loss_r;
    logic loss_nxt;
    logic tx_edge;

    always_comb begin
        tx_edge = sync2_r ^ sync3_r;
        cnt_nxt = cnt_r;
        loss_nxt = loss_r;
        // timed in master clock cycles, never by the tx clock itself
        if (tx_edge) begin
            cnt_nxt = '0;
            loss_nxt = 1'b0;
        end else if (cnt_r <= LIMIT) begin
            cnt_nxt = cnt_r + 1'b1;
        end else begin
            loss_nxt = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            sync3_r <= 1'b0;
            cnt_r <= '0;
            loss_r <= 1'b0;
        end else begin
            sync1_r <= tx_clock;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            cnt_r <= cnt_nxt;
            loss_r <= loss_nxt;
        end
    end

    assign tx_clock_loss_state = loss_r;
endmodule
`default_nettype wire

// [line_event_interrupt_unit.sv]
// Summary of operation
// - config bit disables driver fault monitor; enabled faults show in driver fault state.
// - driver fault state transitions set its pending bit; mask gates the interrupt.
// - a short on the transmit line pair raises an interrupt.
// - hardware control mode keeps the driver fault monitor always enabled.
// - line outputs go high impedance while the master clock is absent.
// - tx clock missing over 70 cycles sets loss state; outputs tri-state unless remote loopback or pattern on master clock.
// - tx clock loss state clears once tx clock activity returns.
// - tx clock loss is timed by the master clock.
// - two-bit config field picks open-drain low, push-pull low or push-pull high.
// - all sources share one interrupt pin; active level means pending.
// - each event is captured in its own pending bit of two registers.
// - each source has its own mask bit in two mask registers.
// - edge select decides which status changes set the pending bit.
// - reading a pending register returns the pin inactive only when no unmasked pending bit remains; host reads acknowledge.
// - fifteen kinds of interrupt events are supported.
// - seven sources have status, pending, edge select and mask bits.
// - eight pulse sources have only pending and mask bits.
// - edge select 0 sets on rising only; 1 sets on any change.
// - reading a pending register clears its bits.
// - mask 0 lets a source through, mask 1 blocks it.
`timescale 1ns/1ps
`default_nettype none
module line_event_interrupt_unit
    import line_event_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [REG_ADDR_W-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [REG_DATA_W-1:0] reg_wdata,
    input wire logic reg_rd,
    output logic [REG_DATA_W-1:0] reg_rdata,
    input wire logic hw_control_mode,
    input wire logic master_clock_absent,
    input wire logic tx_clock,
    input wire logic driver_fault_pin,
    input wire logic remote_loopback,
    input wire logic pattern_on_master_clock,
    input wire logic signal_loss_state,
    input wire logic alarm_indication_state,
    input wire logic pattern_sync_state,
    input wire logic loop_activate_code_state,
    input wire logic loop_deactivate_code_state,
    input wire logic pattern_error_event,
    input wire logic code_violation_event,
    input wire logic excess_zero_event,
    input wire logic jitter_fifo_over_event,
    input wire logic jitter_fifo_under_event,
    input wire logic second_timer_event,
    input wire logic counter_overflow_event,
    input wire logic waveform_overflow_event,
    input wire logic tx_tip_data,
    input wire logic tx_ring_data,
    output logic line_out_tip,
    output logic line_out_ring,
    output logic line_out_oe,
    output logic int_pin_out,
    output logic int_pin_oe,
    output logic line_std_t1
);
    logic [7:0] gcf_r;
    logic [7:0] gcf_nxt;
    logic [7:0] transmit_config_1_r;
    logic [7:0] transmit_config_1_nxt;
    logic [7:0] mask_low_r;
    logic [7:0] mask_low_nxt;
    logic [7:0] mask_high_r;
    logic [7:0] mask_high_nxt;
    logic [7:0] edge_sel_r;
    logic [7:0] edge_sel_nxt;
    logic [7:0] pend_low_r;
    logic [7:0] pend_low_nxt;
    logic [7:0] pend_high_r;
    logic [7:0] pend_high_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;

    logic fault_sync1_r;
    logic fault_sync2_r;
    logic tip_r;
    logic ring_r;
    logic drive_r;
    logic drive_nxt;
    logic int_active_r;
    logic int_active_nxt;

    logic monitor_on;
    logic driver_fault_state;
    logic tx_clock_loss_state;
    logic [LOW_SOURCES-1:0] status_vec;
    logic [LOW_SOURCES-1:0] status_events;
    logic [7:0] status_low;
    logic [7:0] status_high;
    logic [7:0] pulse_events;

    // ---------------------------------------------------------------
    // driver failure monitor
    // ---------------------------------------------------------------
    always_comb begin
        monitor_on = hw_control_mode | ~transmit_config_1_r[TRANSMIT_CONFIG_1_DRIVER_MONITOR_DISABLE_BIT];
        // the fault pin covers a short on the line pair
        driver_fault_state = monitor_on & fault_sync2_r;
    end

    tx_clock_watch #(
        .LOSS_CYCLES(TX_CLOCK_LOSS_CYCLES)
    ) u_tx_clock_watch (
        .ref_clk(ref_clk),
        .rst(rst),
        .tx_clock(tx_clock),
        .tx_clock_loss_state(tx_clock_loss_state)
    );

    // ---------------------------------------------------------------
    // status vector and event capture
    // ---------------------------------------------------------------
    always_comb begin
        status_vec = '0;
        status_vec[SRC_SIGNAL_LOSS] = signal_loss_state;
        status_vec[SRC_ALARM_INDICATION] = alarm_indication_state;
        status_vec[SRC_DRIVER_FAULT] = driver_fault_state;
        status_vec[SRC_TX_CLOCK_LOSS] = tx_clock_loss_state;
        status_vec[SRC_PATTERN_SYNC] = pattern_sync_state;
        status_vec[SRC_LOOP_DEACTIVATE] = loop_deactivate_code_state;
        status_vec[SRC_LOOP_ACTIVATE] = loop_activate_code_state;
        status_low = {1'b0, status_vec};
        status_high = '0;
        status_high[LINE_STATUS_HIGH_REMOTE_LOOP_BIT] = remote_loopback;
        // bit order follows the high mask and pending registers
        pulse_events = {waveform_overflow_event,
                        jitter_fifo_over_event,
                        jitter_fifo_under_event,
                        pattern_error_event,
                        excess_zero_event,
                        code_violation_event,
                        second_timer_event,
                        counter_overflow_event};
    end

    status_edge_capture #(
        .WIDTH(LOW_SOURCES)
    ) u_status_edge_capture (
        .ref_clk(ref_clk),
        .rst(rst),
        .state_in(status_vec),
        .edge_sel(edge_sel_r[LOW_SOURCES-1:0]),
        .event_out(status_events)
    );

    // ---------------------------------------------------------------
    // register file
    // ---------------------------------------------------------------
    always_comb begin
        gcf_nxt = gcf_r;
        transmit_config_1_nxt = transmit_config_1_r;
        mask_low_nxt = mask_low_r;
        mask_high_nxt = mask_high_r;
        edge_sel_nxt = edge_sel_r;
        if (reg_wr) begin
            case (reg_addr)
                OFS_GLOBAL_CONFIGURATION: gcf_nxt = reg_wdata & GCF_WRITE_MASK;
                OFS_TRANSMIT_CONFIG_1: transmit_config_1_nxt = reg_wdata & TRANSMIT_CONFIG_1_WRITE_MASK;
                OFS_INTERRUPT_MASK_LOW: mask_low_nxt = {1'b0, reg_wdata[6:0]};
                OFS_INTERRUPT_MASK_HIGH: mask_high_nxt = reg_wdata;
                OFS_INTERRUPT_EDGE_SELECT: edge_sel_nxt = {1'b0, reg_wdata[6:0]};
                default: ;
            endcase
        end
    end

    // read-back; pending registers clear on the read that returns them
    always_comb begin
        rdata_nxt = rdata_r;
        pend_low_nxt = pend_low_r;
        pend_high_nxt = pend_high_r;
        if (reg_rd) begin
            case (reg_addr)
                OFS_GLOBAL_CONFIGURATION: rdata_nxt = gcf_r;
                OFS_TRANSMIT_CONFIG_1: rdata_nxt = transmit_config_1_r;
                OFS_INTERRUPT_MASK_LOW: rdata_nxt = mask_low_r;
                OFS_INTERRUPT_MASK_HIGH: rdata_nxt = mask_high_r;
                OFS_INTERRUPT_EDGE_SELECT: rdata_nxt = edge_sel_r;
                OFS_LINE_STATUS_LOW: rdata_nxt = status_low;
                OFS_LINE_STATUS_HIGH: rdata_nxt = status_high;
                OFS_INTERRUPT_PENDING_LOW: begin
                    rdata_nxt = pend_low_r;
                    pend_low_nxt = '0;
                end
                OFS_INTERRUPT_PENDING_HIGH: begin
                    rdata_nxt = pend_high_r;
                    pend_high_nxt = '0;
                end
                default: rdata_nxt = '0;
            endcase
        end
        // new events applied after the clear so none is lost on a read
        pend_low_nxt = pend_low_nxt | {1'b0, status_events};
        pend_high_nxt = pend_high_nxt | pulse_events;
    end

    // ---------------------------------------------------------------
    // interrupt pin and line driver enable
    // ---------------------------------------------------------------
    always_comb begin
        // mask 0 passes a source, any passed pending bit drives the pin
        int_active_nxt = |(pend_low_nxt & ~mask_low_nxt) | |(pend_high_nxt & ~mask_high_nxt);
        drive_nxt = ~transmit_config_1_r[TRANSMIT_CONFIG_1_LINE_HIGH_Z_BIT]
                    & ~(tx_clock_loss_state & ~remote_loopback & ~pattern_on_master_clock);
    end

    always_comb begin
        case (gcf_r[GCF_INT_MODE_LSB +: 2])
            INT_MODE_PUSH_PULL_LOW: begin
                int_pin_out = ~int_active_r;
                int_pin_oe = 1'b1;
            end
            INT_MODE_PUSH_PULL_HIGH: begin
                int_pin_out = int_active_r;
                int_pin_oe = 1'b1;
            end
            default: begin
                // open drain: pull low only while active, pull-up gives inactive
                int_pin_out = 1'b0;
                int_pin_oe = int_active_r;
            end
        endcase
    end

    // without a master clock no flop can move, so this gate stays combinational
    assign line_out_oe = drive_r & ~master_clock_absent;
    assign line_out_tip = tip_r;
    assign line_out_ring = ring_r;
    assign reg_rdata = rdata_r;
    assign line_std_t1 = gcf_r[GCF_LINE_STD_BIT];

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            gcf_r <= RST_GLOBAL_CONFIGURATION;
            transmit_config_1_r <= RST_TRANSMIT_CONFIG_1;
            mask_low_r <= RST_INTERRUPT_MASK & 8'h7f;
            mask_high_r <= RST_INTERRUPT_MASK;
            edge_sel_r <= RST_INTERRUPT_EDGE_SELECT;
            pend_low_r <= '0;
            pend_high_r <= '0;
            rdata_r <= '0;
            int_active_r <= 1'b0;
            drive_r <= 1'b0;
            fault_sync1_r <= 1'b0;
            fault_sync2_r <= 1'b0;
            tip_r <= 1'b0;
            ring_r <= 1'b0;
        end else begin
            gcf_r <= gcf_nxt;
            transmit_config_1_r <= transmit_config_1_nxt;
            mask_low_r <= mask_low_nxt;
            mask_high_r <= mask_high_nxt;
            edge_sel_r <= edge_sel_nxt;
            pend_low_r <= pend_low_nxt;
            pend_high_r <= pend_high_nxt;
            rdata_r <= rdata_nxt;
            int_active_r <= int_active_nxt;
            drive_r <= drive_nxt;
            fault_sync1_r <= driver_fault_pin;
            fault_sync2_r <= fault_sync1_r;
            tip_r <= tx_tip_data;
            ring_r <= tx_ring_data;
        end
    end
endmodule
`default_nettype wire

// [line_event_interrupt_unit_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module line_event_interrupt_unit_chk
    import line_event_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [REG_ADDR_W-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [REG_DATA_W-1:0] reg_wdata,
    input wire logic reg_rd,
    input wire logic master_clock_absent,
    input wire logic tx_clock,
    input wire logic remote_loopback,
    input wire logic pattern_on_master_clock,
    input wire logic counter_overflow_event,
    input wire logic line_out_oe,
    input wire logic int_pin_out,
    input wire logic int_pin_oe
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // shadow copies of the registers that decide what the pin means
    logic [1:0] mode_r;
    logic [6:0] mlo_r;
    logic [7:0] mhi_r;
    logic [7:0] idle_r;
    logic act;
    logic all_m;
    assign act = (mode_r == 2'h2) ? int_pin_out : (int_pin_oe && !int_pin_out);
    assign all_m = &{mlo_r, mhi_r};
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            mode_r <= 2'h0;
            mlo_r <= 7'h7f;
            mhi_r <= 8'hff;
            idle_r <= 8'h00;
        end else begin
            if (reg_wr && reg_addr == OFS_GLOBAL_CONFIGURATION) mode_r <= reg_wdata[1:0];
            if (reg_wr && reg_addr == OFS_INTERRUPT_MASK_LOW) mlo_r <= reg_wdata[6:0];
            if (reg_wr && reg_addr == OFS_INTERRUPT_MASK_HIGH) mhi_r <= reg_wdata;
            // saturate so a long idle line never wraps back to zero
            idle_r <= $changed(tx_clock) ? 8'h00 : idle_r + {7'h0, idle_r != 8'hff};
        end
    end
    reset_quiet_a: assert property ($fell(rst) |-> !line_out_oe && !int_pin_oe)
        else $error("outputs active right after reset");
    mclk_off_a: assert property (master_clock_absent |-> !line_out_oe)
        else $error("line driven without master clock");
    txloss_hiz_a: assert property (idle_r > 8'h50 && !remote_loopback && !pattern_on_master_clock
        && !$past(remote_loopback) && !$past(pattern_on_master_clock) |-> !line_out_oe)
        else $error("line driven during tx clock loss");
    pp_drive_a: assert property ((mode_r == 2'h1 || mode_r == 2'h2) |-> int_pin_oe)
        else $error("push-pull pin not driven");
    od_low_a: assert property (mode_r == 2'h0 && int_pin_oe |-> !int_pin_out)
        else $error("open-drain pin driven high");
    unmask_act_a: assert property (counter_overflow_event && !mhi_r[0] |=> act)
        else $error("unmasked event left pin inactive");
    masked_quiet_a: assert property (all_m && $past(all_m) |-> !act)
        else $error("pin active with all sources masked");
    rd_clear_a: assert property (reg_rd && reg_addr == OFS_INTERRUPT_PENDING_HIGH && mlo_r == 7'h7f
        && mhi_r == 8'hfe && !counter_overflow_event |=> !act)
        else $error("pin still active after pending read");
    cover property (counter_overflow_event && !mhi_r[0]);
    cover property (idle_r > 8'h50 && !line_out_oe);
    cover property (reg_rd && reg_addr == OFS_INTERRUPT_PENDING_HIGH ##1 !act);
endmodule
`default_nettype wire

// [host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module host_model
    import line_event_pkg::*;
(
    input wire logic ref_clk,
    input wire logic [REG_DATA_W-1:0] reg_rdata,
    output logic [REG_ADDR_W-1:0] reg_addr,
    output logic reg_wr,
    output logic [REG_DATA_W-1:0] reg_wdata,
    output logic reg_rd
);
    logic [REG_DATA_W-1:0] rdv;
    initial begin
        reg_addr = 5'h00;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        reg_rd = 1'b0;
    end
    // one access every other cycle; released lines show inverted values, not stale ones
    task automatic access(input logic w, input logic [4:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = w;
        reg_rd = !w;
        @(negedge ref_clk);
        rdv = reg_rdata;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask
endmodule
`default_nettype wire

// [test_line_event_interrupt_unit.sv]
`timescale 1ns/1ps
`default_nettype none
module test_line_event_interrupt_unit;
    import line_event_pkg::*;
    typedef struct packed {
        logic [7:0] ev;
        logic [6:0] st;
        logic [7:0] es;
        logic [7:0] exp_lo;
        logic [7:0] exp_hi;
    } row_s;
    row_s rows[6] = '{'{8'h01, 7'h00, 8'h00, 8'h00, 8'h01}, '{8'h80, 7'h00, 8'h00, 8'h00, 8'h80},
        '{8'h5a, 7'h00, 8'h00, 8'h00, 8'h5a}, '{8'h00, 7'h03, 8'h00, 8'h03, 8'h00},
        '{8'h00, 7'h70, 8'h7f, 8'h70, 8'h00}, '{8'ha5, 7'h13, 8'h00, 8'h13, 8'ha5}};
    logic [7:0] act_t[3] = '{8'h02, 8'h02, 8'h03};
    logic [7:0] ina_t[3] = '{8'h00, 8'h03, 8'h02};
    logic ref_clk = 1'b0, rst = 1'b1, tx_clock = 1'b0, tx_run = 1'b1;
    logic hw_control_mode = 1'b0, master_clock_absent = 1'b0, driver_fault_pin = 1'b0;
    logic remote_loopback = 1'b0, pattern_on_master_clock = 1'b0;
    logic [6:0] st = 7'h00;
    logic [7:0] ev = 8'h00;
    logic [4:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata;
    logic reg_wr, reg_rd, line_out_tip, line_out_ring, line_out_oe, int_pin_out, int_pin_oe, line_std_t1;
    int error_cnt = 0;
    int num_checks = 0;
    int cyc = 0;
    always #4 ref_clk = !ref_clk;
    always #21 if (tx_run) tx_clock = !tx_clock;
    host_model host_model_i (.ref_clk, .reg_rdata, .reg_addr, .reg_wr, .reg_wdata, .reg_rd);
    line_event_interrupt_unit line_event_interrupt_unit_i (.ref_clk, .rst, .reg_addr, .reg_wr, .reg_wdata,
        .reg_rd, .reg_rdata, .hw_control_mode, .master_clock_absent, .tx_clock, .driver_fault_pin,
        .remote_loopback, .pattern_on_master_clock, .signal_loss_state(st[0]), .alarm_indication_state(st[1]),
        .pattern_sync_state(st[4]), .loop_deactivate_code_state(st[5]), .loop_activate_code_state(st[6]),
        .counter_overflow_event(ev[0]), .second_timer_event(ev[1]), .code_violation_event(ev[2]),
        .excess_zero_event(ev[3]), .pattern_error_event(ev[4]), .jitter_fifo_under_event(ev[5]),
        .jitter_fifo_over_event(ev[6]), .waveform_overflow_event(ev[7]), .tx_tip_data(tx_clock),
        .tx_ring_data(!tx_clock), .line_out_tip, .line_out_ring, .line_out_oe, .int_pin_out, .int_pin_oe,
        .line_std_t1);
    task automatic test_done();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp);
        host_model_i.access(1'b0, a, 8'h00);
        chk(host_model_i.rdv, exp);
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        host_model_i.access(1'b1, a, d);
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    // a released pin (output enable low) reads as not driven, whatever the output bit holds
    function automatic logic [7:0] pin();
        return {6'h0, int_pin_oe, int_pin_oe & int_pin_out};
    endfunction
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            test_done();
        end
    end
    initial begin
        tick(4);
        rst = 1'b0;
        for (int i = 0; i < 6; i++) begin
            wr(OFS_INTERRUPT_EDGE_SELECT, rows[i].es);
            st = rows[i].st;
            ev = rows[i].ev;
            tick(1);
            ev = 8'h00;
            tick(3);
            rd_chk(OFS_LINE_STATUS_LOW, {1'b0, rows[i].st});
            rd_chk(OFS_INTERRUPT_PENDING_LOW, rows[i].exp_lo);
            rd_chk(OFS_INTERRUPT_PENDING_HIGH, rows[i].exp_hi);
            st = 7'h00;
            tick(3);
            rd_chk(OFS_INTERRUPT_PENDING_LOW, {1'b0, rows[i].es[6:0] & rows[i].st});
            rd_chk(OFS_INTERRUPT_PENDING_LOW, 8'h00);
        end
        rst = 1'b1;
        tick(4);
        rst = 1'b0;
        chk({7'h0, int_pin_oe}, 8'h00);
        rd_chk(OFS_GLOBAL_CONFIGURATION, 8'h00);
        rd_chk(OFS_TRANSMIT_CONFIG_1, 8'h00);
        rd_chk(OFS_INTERRUPT_MASK_LOW, 8'h7f);
        rd_chk(OFS_INTERRUPT_MASK_HIGH, 8'hff);
        rd_chk(OFS_INTERRUPT_EDGE_SELECT, 8'h00);
        rd_chk(5'h1f, 8'h00);
        wr(OFS_GLOBAL_CONFIGURATION, 8'hfc);
        rd_chk(OFS_GLOBAL_CONFIGURATION, 8'h04);
        chk({7'h0, line_std_t1}, 8'h01);
        wr(OFS_LINE_STATUS_LOW, 8'hff);
        rd_chk(OFS_LINE_STATUS_LOW, 8'h00);
        wr(OFS_INTERRUPT_MASK_HIGH, 8'hfe);
        for (int m = 0; m < 3; m++) begin
            wr(OFS_GLOBAL_CONFIGURATION, m[7:0]);
            chk(pin(), ina_t[m]);
            ev = 8'h01;
            tick(1);
            ev = 8'h00;
            chk(pin(), act_t[m]);
            rd_chk(OFS_INTERRUPT_PENDING_HIGH, 8'h01);
            chk(pin(), ina_t[m]);
        end
        wr(OFS_INTERRUPT_MASK_HIGH, 8'hff);
        ev = 8'h01;
        tick(1);
        ev = 8'h00;
        chk(pin(), 8'h02);
        rd_chk(OFS_INTERRUPT_PENDING_HIGH, 8'h01);
        wr(OFS_INTERRUPT_MASK_LOW, 8'h7b);
        driver_fault_pin = 1'b1;
        tick(6);
        chk(pin(), 8'h03);
        rd_chk(OFS_LINE_STATUS_LOW, 8'h04);
        rd_chk(OFS_INTERRUPT_PENDING_LOW, 8'h04);
        wr(OFS_TRANSMIT_CONFIG_1, 8'h20);
        rd_chk(OFS_LINE_STATUS_LOW, 8'h00);
        hw_control_mode = 1'b1;
        tick(3);
        rd_chk(OFS_LINE_STATUS_LOW, 8'h04);
        driver_fault_pin = 1'b0;
        hw_control_mode = 1'b0;
        wr(OFS_TRANSMIT_CONFIG_1, 8'h00);
        tx_run = 1'b0;
        tick(60);
        rd_chk(OFS_LINE_STATUS_LOW, 8'h00);
        // tx clock is frozen here, so the registered line data has settled
        chk({6'h0, line_out_tip, line_out_ring}, {6'h0, tx_clock, !tx_clock});
        tick(20);
        rd_chk(OFS_LINE_STATUS_LOW, 8'h08);
        chk({7'h0, line_out_oe}, 8'h00);
        remote_loopback = 1'b1;
        tick(2);
        chk({7'h0, line_out_oe}, 8'h01);
        remote_loopback = 1'b0;
        tx_run = 1'b1;
        tick(10);
        rd_chk(OFS_LINE_STATUS_LOW, 8'h00);
        chk({7'h0, line_out_oe}, 8'h01);
        master_clock_absent = 1'b1;
        #1;
        chk({7'h0, line_out_oe}, 8'h00);
        master_clock_absent = 1'b0;
        tick(2);
        test_done();
    end
endmodule
bind line_event_interrupt_unit line_event_interrupt_unit_chk line_event_interrupt_unit_chk_i (.ref_clk, .rst,
    .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .master_clock_absent, .tx_clock, .remote_loopback,
    .pattern_on_master_clock, .counter_overflow_event, .line_out_oe, .int_pin_out, .int_pin_oe);
`default_nettype wire
